// file: hw/phy_mgmt_pkg.sv
/*
  package for the phy management master: register locations, status field
  positions, pattern constants, frequency window figures and carrier structs.
  assumes a single 100 MHz management clock drives every user of it.
*/
package phy_mgmt_pkg;

  // byte addresses of phy registers, retargetable per protocol
  localparam logic [9:0] CHAN_SEL_LOC_DEF = 10'h200;
  localparam logic [9:0] CODING_STAT_LOC_DEF = 10'h204;
  localparam logic [9:0] LOOPBACK_LOC_DEF = 10'h184;

  localparam logic [31:0] CHAN_SEL_VALUE = 32'h00000000;
  localparam logic [31:0] LOOPBACK_ON_VALUE = 32'h00000001;

  // bit positions inside the receive coding status word
  localparam int STAT_WORD_LOCK = 0;
  localparam int STAT_SYNC_LOCK = 1;
  localparam int STAT_FRAMING_ERR = 2;
  localparam int STAT_CHECKSUM_ERR = 3;
  localparam int STAT_SCRAMBLER_ERR = 4;
  localparam int STAT_SYNC_WORD_ERR = 5;

  // pattern source and checker
  localparam int PAT_WIDTH = 64;
  localparam int PAT_ORDER = 23;
  localparam int PAT_TAP = 18;
  localparam logic [22:0] PAT_SEED = 23'h7FFFFF;
  localparam logic [4:0] PAT_LOCK_WORDS = 5'h10;

  // user clock rate check: ticks counted over a fixed window
  localparam int CLK_PERIOD_NS = 10;
  localparam int FREQ_WINDOW_NS = 10000;
  localparam int FREQ_WINDOW_CYCLES = FREQ_WINDOW_NS / CLK_PERIOD_NS;
  localparam logic [10:0] FREQ_TICKS_MIN = 11'h1E0;
  localparam logic [10:0] FREQ_TICKS_MAX = 11'h208;

  typedef struct packed {
    logic read;
    logic write;
    logic [8:0] address;
    logic [31:0] writedata;
  } mgmt_req_type;

  typedef struct packed {
    logic sync_lock;
    logic word_lock;
    logic framing_error;
    logic checksum_fault;
    logic scrambler_error;
    logic sync_word_error;
  } rx_status_type;

endpackage

// file: hw/phy_mgmt_status_master.sv
/*
  phy management master with status outputs, loopback pattern source and
  checker, and user clock rate watch.
  assumes the phy management port answers with waitrequest and presents
  read data in the cycle that waitrequest is low; all inputs are synchronous
  to clk, and the user clock ticks arrive as one-cycle pulses on clk.
*/
// Functional notes
// R1: byte address in, word address out
// R2: read and write data are 32 bits
// R3: channel and status locations are parameters
// R4: write loopback control to enable serial loopback
// R5: framing error flag follows receive path
// R6: checksum fault flag follows receive path
// R7: scrambler error flag follows receive path
// R8: missing sync word flag follows receive path
// R9: tx and rx clock rate fault flags
// R10: pattern mismatch flag on wrong word
// R11: pattern locked flag once checker synchronised
// R12: 64-bit PRBS-23 generator and checker
// R13: sync lock after four sync words
// R14: word lock at first alignment pattern
// R15: hold transfer stable while waitrequest high
// R16: wait for both ready, then loopback, then poll
`timescale 1ns/100ps
module phy_mgmt_status_master #(
  parameter logic [9:0] CHAN_SEL_LOC = phy_mgmt_pkg::CHAN_SEL_LOC_DEF,
  parameter logic [9:0] CODING_STAT_LOC = phy_mgmt_pkg::CODING_STAT_LOC_DEF,
  parameter logic [9:0] LOOPBACK_LOC = phy_mgmt_pkg::LOOPBACK_LOC_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tx_ready,
  input wire logic rx_ready,
  input wire logic [31:0] mgmt_readdata,
  input wire logic mgmt_waitrequest,
  output phy_mgmt_pkg::mgmt_req_type mgmt_req,
  input wire logic [9:0] core_address,
  input wire logic core_read,
  input wire logic core_write,
  input wire logic [31:0] core_writedata,
  output logic [31:0] core_readdata,
  output logic core_done,
  output phy_mgmt_pkg::rx_status_type rx_status,
  input wire logic tx_clk_tick,
  input wire logic rx_clk_tick,
  output logic tx_clk_fault,
  output logic rx_clk_fault,
  output logic [63:0] tx_pattern,
  input wire logic [63:0] rx_pattern,
  output logic pattern_mismatch,
  output logic pattern_locked
);

  typedef enum logic [2:0] {
    S_WAIT_READY = 3'b000,
    S_CHAN = 3'b001,
    S_LOOP = 3'b010,
    S_POLL = 3'b011,
    S_CORE = 3'b100
  } state_type;

  // drop the byte-offset bit to form the phy word address
  function automatic logic [8:0] word_addr(input logic [9:0] byte_addr);
    word_addr = byte_addr[9:1]; // R1
  endfunction

  // advance the 23-bit sequence by one word, first bit in bit 0
  function automatic logic [86:0] pat_step(input logic [22:0] seed);
    logic [22:0] s;
    logic [63:0] w;
    logic nb;
    s = seed;
    w = 64'h0000000000000000;
    for (int i = 0; i < phy_mgmt_pkg::PAT_WIDTH; i++) begin
      nb = s[phy_mgmt_pkg::PAT_ORDER - 1] ^ s[phy_mgmt_pkg::PAT_TAP - 1];
      s = {s[21:0], nb};
      w[i] = nb;
    end
    pat_step = {s, w};
  endfunction

  function automatic logic rate_bad(input logic [10:0] ticks);
    rate_bad = (ticks < phy_mgmt_pkg::FREQ_TICKS_MIN) || (ticks > phy_mgmt_pkg::FREQ_TICKS_MAX);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // management sequencer

  state_type state_r, state_nxt;
  phy_mgmt_pkg::mgmt_req_type req_r, req_nxt;
  logic [31:0] core_readdata_r;
  logic core_done_r;
  phy_mgmt_pkg::rx_status_type status_r;

  wire both_ready = tx_ready && rx_ready;
  wire busy = req_r.read || req_r.write;
  wire xfer_done = busy && !mgmt_waitrequest; // R15
  wire core_req = core_read || core_write;
  wire [31:0] st = mgmt_readdata;

  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    if (!busy || xfer_done) begin
      req_nxt = '0;
      case (state_r)
        S_WAIT_READY: begin
          if (both_ready) begin // R16
            state_nxt = S_CHAN;
            req_nxt.write = 1'b1;
            req_nxt.address = word_addr(CHAN_SEL_LOC); // R3
            req_nxt.writedata = phy_mgmt_pkg::CHAN_SEL_VALUE;
          end
        end
        S_CHAN: begin
          if (xfer_done) begin
            state_nxt = S_LOOP;
            req_nxt.write = 1'b1;
            req_nxt.address = word_addr(LOOPBACK_LOC); // R4
            req_nxt.writedata = phy_mgmt_pkg::LOOPBACK_ON_VALUE;
          end
        end
        S_LOOP, S_POLL, S_CORE: begin
          // a core access is slotted between status polls so both make progress
          if (core_req && state_r != S_CORE && !core_done_r) begin
            state_nxt = S_CORE;
            req_nxt.read = core_read;
            req_nxt.write = core_write && !core_read;
            req_nxt.address = word_addr(core_address); // R1
            req_nxt.writedata = core_writedata; // R2
          end else begin
            state_nxt = S_POLL;
            req_nxt.read = 1'b1; // R16
            req_nxt.address = word_addr(CODING_STAT_LOC); // R3
          end
        end
        default: begin
          state_nxt = S_WAIT_READY;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= S_WAIT_READY;
      req_r <= '0;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt; // R15
    end
  end

  // core completion and status capture
  always_ff @(posedge clk) begin
    if (!rstn) begin
      core_readdata_r <= 32'h00000000;
      core_done_r <= 1'b0;
      status_r <= '0;
    end else begin
      core_done_r <= xfer_done && state_r == S_CORE;
      if (xfer_done && state_r == S_CORE && req_r.read) begin
        core_readdata_r <= mgmt_readdata; // R2
      end
      if (xfer_done && state_r == S_POLL) begin
        status_r.word_lock <= st[phy_mgmt_pkg::STAT_WORD_LOCK]; // R14
        status_r.sync_lock <= st[phy_mgmt_pkg::STAT_SYNC_LOCK]; // R13
        status_r.framing_error <= st[phy_mgmt_pkg::STAT_FRAMING_ERR]; // R5
        status_r.checksum_fault <= st[phy_mgmt_pkg::STAT_CHECKSUM_ERR]; // R6
        status_r.scrambler_error <= st[phy_mgmt_pkg::STAT_SCRAMBLER_ERR]; // R7
        status_r.sync_word_error <= st[phy_mgmt_pkg::STAT_SYNC_WORD_ERR]; // R8
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // user clock rate watch

  logic [15:0] win_cnt_r;
  logic [10:0] tx_ticks_r, rx_ticks_r;
  logic tx_fault_r, rx_fault_r;
  wire win_end = (win_cnt_r == 16'(phy_mgmt_pkg::FREQ_WINDOW_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      win_cnt_r <= 16'h0000;
      tx_ticks_r <= 11'h000;
      rx_ticks_r <= 11'h000;
      tx_fault_r <= 1'b0;
      rx_fault_r <= 1'b0;
    end else if (win_end) begin
      win_cnt_r <= 16'h0000;
      tx_ticks_r <= 11'h000;
      rx_ticks_r <= 11'h000;
      tx_fault_r <= rate_bad(tx_ticks_r); // R9
      rx_fault_r <= rate_bad(rx_ticks_r); // R9
    end else begin
      win_cnt_r <= win_cnt_r + 16'h0001;
      // saturate so a runaway clock still reads as out of range
      if (tx_clk_tick && tx_ticks_r != 11'h7FF) begin
        tx_ticks_r <= tx_ticks_r + 11'h001;
      end
      if (rx_clk_tick && rx_ticks_r != 11'h7FF) begin
        rx_ticks_r <= rx_ticks_r + 11'h001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pattern generator and self-synchronising checker

  logic [22:0] gen_seed_r;
  logic [63:0] gen_word_r;
  logic [63:0] rx_prev_r;
  logic [4:0] good_cnt_r;
  logic locked_r, mismatch_r;
  // next state in the top 23 bits, next word in the low 64
  wire [86:0] gen_next = pat_step(gen_seed_r);
  wire [127:0] rx_hist = {rx_pattern, rx_prev_r};
  logic word_bad;

  // each received bit must equal the xor of its two tap predecessors
  always_comb begin
    word_bad = 1'b0;
    for (int i = 64; i < 128; i++) begin
      if (rx_hist[i] != (rx_hist[i - phy_mgmt_pkg::PAT_ORDER] ^ rx_hist[i - phy_mgmt_pkg::PAT_TAP])) begin
        word_bad = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      gen_seed_r <= phy_mgmt_pkg::PAT_SEED;
      gen_word_r <= 64'h0000000000000000;
      rx_prev_r <= 64'h0000000000000000;
      good_cnt_r <= 5'h00;
      locked_r <= 1'b0;
      mismatch_r <= 1'b0;
    end else begin
      gen_seed_r <= gen_next[86:64]; // R12
      gen_word_r <= gen_next[63:0]; // R12
      rx_prev_r <= rx_pattern;
      if (word_bad) begin
        good_cnt_r <= 5'h00;
      end else if (good_cnt_r != phy_mgmt_pkg::PAT_LOCK_WORDS) begin
        good_cnt_r <= good_cnt_r + 5'h01;
      end
      if (!word_bad && good_cnt_r == phy_mgmt_pkg::PAT_LOCK_WORDS - 5'h01) begin
        locked_r <= 1'b1; // R11
      end
      // before lock a bad word is just search, after lock it is a fault
      if (locked_r && word_bad) begin
        mismatch_r <= 1'b1; // R10
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign mgmt_req = req_r;
  assign core_readdata = core_readdata_r;
  assign core_done = core_done_r;
  assign rx_status = status_r;
  assign tx_clk_fault = tx_fault_r;
  assign rx_clk_fault = rx_fault_r;
  assign tx_pattern = gen_word_r;
  assign pattern_mismatch = mismatch_r;
  assign pattern_locked = locked_r;

endmodule // phy_mgmt_status_master

// file: testbench/phy_mgmt_status_master_asserts.sv
/* assertions on the phy management master ports.
   assumes one clock, rstn synchronous and active low. */
`timescale 1ns/100ps
module phy_mgmt_status_master_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tx_ready,
  input wire logic rx_ready,
  input wire logic [31:0] mgmt_readdata,
  input wire logic mgmt_waitrequest,
  input phy_mgmt_pkg::mgmt_req_type mgmt_req,
  input wire logic core_done,
  input phy_mgmt_pkg::rx_status_type rx_status,
  input wire logic pattern_mismatch,
  input wire logic pattern_locked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic seen_r;
  wire busy = mgmt_req.read | mgmt_req.write;
  wire poll = mgmt_req.read & !mgmt_waitrequest & (mgmt_req.address == 9'h102);
  wire [3:0] err_w = {mgmt_readdata[2], mgmt_readdata[3], mgmt_readdata[4], mgmt_readdata[5]};
  always_ff @(posedge clk) seen_r <= rstn & (seen_r | (tx_ready & rx_ready));
  chk_stall_hold: assert property (busy && mgmt_waitrequest |=> $stable(mgmt_req))
    else $error("request moved in stall");
  chk_ready_first: assert property (!seen_r |-> !busy) else $error("early request");
  chk_loop_data: assert property (mgmt_req.write && mgmt_req.address == 9'h0C2
    |-> mgmt_req.writedata == 32'h1) else $error("bad loopback data");
  chk_lock_bits: assert property (poll |=> rx_status[5:4] == $past(mgmt_readdata[1:0]))
    else $error("lock bits wrong");
  chk_err_bits: assert property (poll |=> rx_status[3:0] == $past(err_w))
    else $error("error bits wrong");
  chk_done_cause: assert property (core_done |-> $past(busy && !mgmt_waitrequest))
    else $error("done without transfer");
  chk_lock_stay: assert property (pattern_locked |=> pattern_locked)
    else $error("lock dropped");
  chk_bad_stay: assert property (pattern_mismatch |=> pattern_mismatch && pattern_locked)
    else $error("mismatch dropped");
endmodule // phy_mgmt_status_master_asserts
bind phy_mgmt_status_master phy_mgmt_status_master_asserts phy_mgmt_status_master_asserts_i (
  .clk(clk), .rstn(rstn), .tx_ready(tx_ready), .rx_ready(rx_ready), .core_done(core_done),
  .mgmt_readdata(mgmt_readdata), .mgmt_waitrequest(mgmt_waitrequest), .mgmt_req(mgmt_req),
  .rx_status(rx_status), .pattern_mismatch(pattern_mismatch), .pattern_locked(pattern_locked));

// file: testbench/phy_mgmt_phy_model.sv
/* phy management port model: register array, status word, random stall.
   assumes requests change just after rising edges of clk. */
`timescale 1ns/100ps
module phy_mgmt_phy_model (
  input wire logic clk,
  input wire logic rstn,
  input phy_mgmt_pkg::mgmt_req_type mgmt_req,
  input wire logic [5:0] status_bits,
  output logic [31:0] mgmt_readdata,
  output logic mgmt_waitrequest = 1'h0,
  output logic loopback_on = 1'h0
);
  logic [31:0] mem [512];
  logic [31:0] last_r = 32'h0;
  wire [8:0] adr = mgmt_req.address;
  wire rd_ok = mgmt_req.read & !mgmt_waitrequest;
  wire wr_ok = mgmt_req.write & !mgmt_waitrequest;
  always @(posedge clk) begin
    mgmt_waitrequest <= rstn && ($urandom % 3 == 0);
    if (wr_ok) mem[adr] <= mgmt_req.writedata;
    loopback_on <= rstn & ((wr_ok && adr == 9'h0C2) ? mgmt_req.writedata[0] : loopback_on);
    if (rd_ok) last_r <= mgmt_readdata;
  end
  // idle bus shows the inverse of the last word, so stale data never matches
  assign mgmt_readdata = !rd_ok ? ~last_r :
    (adr == 9'h102) ? {26'h0, status_bits} : mem[adr];
endmodule // phy_mgmt_phy_model

// file: testbench/phy_mgmt_status_master_test.sv
/* self-checking bench: design, phy model, tick and pattern loop stimulus.
   assumes the package and design files are compiled first. */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
`define WT(c, m) begin for (n = 0; n < m && !(c); n++) @(posedge clk); \
  if (!(c)) begin bad_count++; $display("[ERR] wait exp 1 got 0"); report_and_stop; end end
module phy_mgmt_status_master_test;
  logic clk = 1'h0, rstn = 1'h0, txr = 1'h0, rxr = 1'h0, crd = 1'h0, cwr = 1'h0;
  logic ttk = 1'h0, rtk = 1'h0, corrupt = 1'h0;
  logic [127:0] h;
  logic [9:0] cadr = 10'h0;
  logic [31:0] cwd = 32'h0, last_rd = 32'h0, d, e;
  logic [5:0] sb = 6'h0, b, x;
  logic [31:0] q[$];
  int bad_count = 0, checks = 0, n, i, j, hb, tk = 0;
  phy_mgmt_pkg::mgmt_req_type rq;
  phy_mgmt_pkg::rx_status_type st;
  wire [31:0] rdat, crdat;
  wire [63:0] tp;
  wire [63:0] rp = tp ^ {63'h0, corrupt};
  wire wreq, done, tflt, rflt, bad, lck, lb;
  phy_mgmt_status_master phy_mgmt_status_master_i (.clk(clk), .rstn(rstn), .tx_ready(txr),
    .rx_ready(rxr), .mgmt_readdata(rdat), .mgmt_waitrequest(wreq), .mgmt_req(rq),
    .core_address(cadr), .core_read(crd), .core_write(cwr), .core_writedata(cwd),
    .core_readdata(crdat), .core_done(done), .rx_status(st), .tx_clk_tick(ttk),
    .rx_clk_tick(rtk), .tx_clk_fault(tflt), .rx_clk_fault(rflt), .tx_pattern(tp),
    .rx_pattern(rp), .pattern_mismatch(bad), .pattern_locked(lck));
  phy_mgmt_phy_model phy_mgmt_phy_model_i (.clk(clk), .rstn(rstn), .mgmt_req(rq),
    .status_bits(sb), .mgmt_readdata(rdat), .mgmt_waitrequest(wreq), .loopback_on(lb));
  initial forever #5 clk = ~clk;
  // tx ticks every 2nd cycle sit inside the window, rx every 3rd fall short
  always @(posedge clk) begin
    tk <= tk + 1;
    ttk <= (tk % 2 == 0);
    rtk <= (tk % 3 == 0);
  end
  always @(posedge clk) if (done === 1'h1) begin
    e = q.size() ? q.pop_front() : 32'hX;
    `CHK("core_readdata", e, crdat)
  end
  task report_and_stop;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task acc(input logic w, input logic [9:0] a, input logic [31:0] dd);
    cadr <= a;
    cwd <= dd;
    cwr <= w;
    crd <= !w;
    q.push_back(w ? last_rd : dd);
    if (!w) last_rd = dd;
    `WT(done === 1'h1, 300)
    crd <= 1'h0;
    cwr <= 1'h0;
    @(posedge clk);
  endtask
  initial begin
    void'($urandom(32'h24E7A37A));
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    txr <= 1'h1;
    repeat (20) @(posedge clk);
    `CHK("loopback_on", 1'h0, lb)
    rxr <= 1'h1;
    `WT(lb === 1'h1, 100)
    `CHK("loopback_on", 1'h1, lb)
    $display("test ready done");
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      acc(1'h1, 10'h40 + 10'(i * 8), d);
      acc(1'h0, 10'h40 + 10'(i * 8), d);
      acc(1'h0, 10'h41 + 10'(i * 8), d);
    end
    $display("test core done");
    for (i = 0; i < 8; i++) begin
      d = $urandom;
      b = (i < 6) ? 6'(1 << i) : d[5:0];
      x = {b[1], b[0], b[2], b[3], b[4], b[5]};
      sb <= b;
      `WT(st === x, 200)
      `CHK("rx_status", x, st)
    end
    $display("test status done");
    `WT(lck === 1'h1, 100)
    `CHK("pattern_mismatch", 1'h0, bad)
    // the loop alone would lock on an all-zero source, so test the source itself
    h[63:0] = tp;
    @(posedge clk);
    h[127:64] = tp;
    hb = 0;
    for (j = 64; j < 128; j++) begin
      hb += (h[j] != (h[j - phy_mgmt_pkg::PAT_ORDER] ^ h[j - phy_mgmt_pkg::PAT_TAP]));
    end
    `CHK("tx_pattern_rule", 0, hb)
    `CHK("tx_pattern_live", 1'h1, |tp)
    corrupt <= 1'h1;
    @(posedge clk);
    corrupt <= 1'h0;
    `WT(bad === 1'h1, 8)
    repeat (20) @(posedge clk);
    `CHK("pattern_mismatch", 1'h1, bad)
    $display("test pattern done");
    `WT(rflt === 1'h1, 2500)
    `CHK("tx_clk_fault", 1'h0, tflt)
    `CHK("rx_clk_fault", 1'h1, rflt)
    $display("test clock done");
    report_and_stop;
  end
endmodule // phy_mgmt_status_master_test
